// ### hw/plc_defines.svh
// Register offsets, reset values and bus codes for the parallel line controller
`ifndef PLC_DEFINES_SVH
`define PLC_DEFINES_SVH

`define PLC_ADDR_W          8
`define PLC_OFS_LINE_TAKE   8'h00
`define PLC_OFS_LINE_REL    8'h04
`define PLC_OFS_OWNER       8'h08
`define PLC_OFS_DRV_ON      8'h10
`define PLC_OFS_DRV_OFF     8'h14
`define PLC_OFS_DRV_STATE   8'h18
`define PLC_OFS_FILT_ON     8'h20
`define PLC_OFS_FILT_OFF    8'h24
`define PLC_OFS_FILT_STATE  8'h28
`define PLC_OFS_DRV_HIGH    8'h30
`define PLC_OFS_DRV_LOW     8'h34
`define PLC_OFS_DRV_LATCH   8'h38
`define PLC_OFS_PIN_LEVEL   8'h3C
`define PLC_OFS_IRQ_ON      8'h40
`define PLC_OFS_IRQ_OFF     8'h44
`define PLC_OFS_IRQ_MASK    8'h48
`define PLC_OFS_PENDING     8'h4C
`define PLC_OFS_WPERM_ON    8'hA0
`define PLC_OFS_WPERM_OFF   8'hA4
`define PLC_OFS_WPERM_STATE 8'hA8

`define PLC_RST_WORD        32'h00000000
`define PLC_RST_ALL_LINES   32'hFFFFFFFF
`define PLC_HRESP_OKAY      1'b0
`define PLC_SYNC_STAGES     3

`endif

// ### hw/plc_pkg.sv
// Types shared by the parallel line controller
package plc_pkg;

	typedef logic [31:0] plc_word_t;

	typedef enum logic [0:0] {
		PLC_PH_IDLE = 1'b0,
		PLC_PH_DATA = 1'b1
	} plc_phase_t;

endpackage

// ### hw/plc_line_input.sv
// Pin input synchroniser and glitch filter, one slice per line
module plc_line_input
	import plc_pkg::*;
#(
	parameter int LINES = 32
) (
	input  wire logic             ref_clk,
	input  wire logic             reset,
	input  wire logic [LINES-1:0] pad_in,
	input  wire logic [LINES-1:0] filter_on,
	output logic      [LINES-1:0] level
);

	genvar gi;
	generate
		for (gi = 0; gi < LINES; gi++) begin : g_line
			logic s1;
			logic s2;
			logic s3;
			logic s4;
			logic clean;
			logic filt;
			// First stage feeds only the second one
			always_ff @(posedge ref_clk or posedge reset) begin
				if (reset) begin
					s1    <= 1'b0;
					s2    <= 1'b0;
					s3    <= 1'b0;
					s4    <= 1'b0;
					clean <= 1'b0;
					filt  <= 1'b0;
				end else begin
					s1 <= pad_in[gi];
					s2 <= s1;
					s3 <= s2;
					s4 <= s3;
					if (s2 == s3) begin
						clean <= s2;
					end
					// Pulses of two cycles or less never reach filt
					if (s2 == s3 && s3 == s4) begin
						filt <= s2;
					end
				end
			end
			assign level[gi] = filter_on[gi] ? filt : clean;
		end
	endgenerate

endmodule

// ### hw/plc_top.sv
// Parallel line controller: AHB-Lite registers, pin muxing, change interrupt
//
// Our own choices: the AHB-Lite register port and the register addresses.
`include "plc_defines.svh"
module plc_top
	import plc_pkg::*;
#(
	parameter logic [31:0] IMPL_MASK   = `PLC_RST_ALL_LINES,
	parameter logic [31:0] MUXED_MASK  = `PLC_RST_ALL_LINES,
	parameter logic [31:0] OWNER_RESET = `PLC_RST_WORD
) (
	input  wire logic        ref_clk,
	input  wire logic        reset,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic      [31:0] hrdata,
	input  wire logic [31:0] pad_in,
	output logic      [31:0] pad_out,
	output logic      [31:0] pad_oe,
	input  wire logic [31:0] periph_out,
	input  wire logic [31:0] periph_oe,
	output logic      [31:0] periph_in,
	output logic             irq
);

	// Implemented lines that are not multiplexed always belong to the controller
	localparam plc_word_t FIXED_OWN = IMPL_MASK & ~MUXED_MASK;

	function automatic logic hit(input logic [`PLC_ADDR_W-1:0] a,
		input logic [`PLC_ADDR_W-1:0] ofs);
		hit = (a == ofs);
	endfunction

	plc_phase_t                  phase;
	logic [`PLC_ADDR_W-1:0]      addr_q;
	logic                        wr_q;
	logic                        sel_hi_q;
	plc_word_t                   owner;
	plc_word_t                   driver;
	plc_word_t                   filt_en;
	plc_word_t                   odata;
	plc_word_t                   irq_mask;
	plc_word_t                   wperm;
	plc_word_t                   pending;
	plc_word_t                   pin_q;
	plc_word_t                   pin_prev;
	logic                        primed;
	plc_word_t                   level;
	plc_word_t                   rd_mux;
	plc_word_t                   next_owner;
	plc_word_t                   next_driver;
	plc_word_t                   next_filt_en;
	plc_word_t                   next_odata;
	plc_word_t                   next_irq_mask;
	plc_word_t                   next_wperm;
	plc_word_t                   next_pending;

	// Address phase taken only with hready high
	wire       take     = hsel && htrans[1] && hready;
	wire       data_go  = (phase == PLC_PH_DATA);
	wire       wr_go    = data_go && wr_q && !sel_hi_q;
	wire       rd_go    = data_go && !wr_q && !sel_hi_q;
	wire [31:0] wdat    = hwdata & IMPL_MASK;
	// Unimplemented lines drop every written bit
	wire [31:0] w_take  = wr_go && hit(addr_q, `PLC_OFS_LINE_TAKE)  ? wdat : '0;
	wire [31:0] w_rel   = wr_go && hit(addr_q, `PLC_OFS_LINE_REL)   ? wdat : '0;
	wire [31:0] w_don   = wr_go && hit(addr_q, `PLC_OFS_DRV_ON)     ? wdat : '0;
	wire [31:0] w_doff  = wr_go && hit(addr_q, `PLC_OFS_DRV_OFF)    ? wdat : '0;
	wire [31:0] w_fon   = wr_go && hit(addr_q, `PLC_OFS_FILT_ON)    ? wdat : '0;
	wire [31:0] w_foff  = wr_go && hit(addr_q, `PLC_OFS_FILT_OFF)   ? wdat : '0;
	wire [31:0] w_high  = wr_go && hit(addr_q, `PLC_OFS_DRV_HIGH)   ? wdat : '0;
	wire [31:0] w_low   = wr_go && hit(addr_q, `PLC_OFS_DRV_LOW)    ? wdat : '0;
	wire [31:0] w_ion   = wr_go && hit(addr_q, `PLC_OFS_IRQ_ON)     ? wdat : '0;
	wire [31:0] w_ioff  = wr_go && hit(addr_q, `PLC_OFS_IRQ_OFF)    ? wdat : '0;
	wire [31:0] w_pon   = wr_go && hit(addr_q, `PLC_OFS_WPERM_ON)   ? wdat : '0;
	wire [31:0] w_poff  = wr_go && hit(addr_q, `PLC_OFS_WPERM_OFF)  ? wdat : '0;
	wire [31:0] w_pend  = wr_go && hit(addr_q, `PLC_OFS_PENDING)    ? wdat : '0;
	wire        w_latch = wr_go && hit(addr_q, `PLC_OFS_DRV_LATCH);
	wire        rd_pend = rd_go && hit(addr_q, `PLC_OFS_PENDING);
	wire [31:0] w_lmask = w_latch ? (wperm & IMPL_MASK) : '0;
	wire [31:0] chg_set = primed ? ((pin_q ^ pin_prev) & irq_mask) : '0;

	// one stored bit per command pair
	assign next_owner    = (((owner | w_take) & ~w_rel) & IMPL_MASK) | FIXED_OWN;
	assign next_driver   = (driver | w_don) & ~w_doff & IMPL_MASK;
	assign next_filt_en  = (filt_en | w_fon) & ~w_foff & IMPL_MASK;
	assign next_odata    = ((((odata | w_high) & ~w_low) & ~w_lmask) | (hwdata & w_lmask))
		& IMPL_MASK;
	assign next_irq_mask = (irq_mask | w_ion) & ~w_ioff & IMPL_MASK;
	assign next_wperm    = (wperm | w_pon) & ~w_poff & IMPL_MASK;
	// new changes win over read or write-one clear
	assign next_pending  = ((rd_pend ? '0 : (pending & ~w_pend)) | chg_set) & IMPL_MASK;

	// Read decode; status views
	always_comb begin
		if (hit(addr_q, `PLC_OFS_OWNER)) begin
			rd_mux = owner;
		end else if (hit(addr_q, `PLC_OFS_DRV_STATE)) begin
			rd_mux = driver;
		end else if (hit(addr_q, `PLC_OFS_FILT_STATE)) begin
			rd_mux = filt_en;
		end else if (hit(addr_q, `PLC_OFS_DRV_LATCH)) begin
			rd_mux = odata;
		end else if (hit(addr_q, `PLC_OFS_PIN_LEVEL)) begin
			rd_mux = pin_q;
		end else if (hit(addr_q, `PLC_OFS_IRQ_MASK)) begin
			rd_mux = irq_mask;
		end else if (hit(addr_q, `PLC_OFS_PENDING)) begin
			rd_mux = pending;
		end else if (hit(addr_q, `PLC_OFS_WPERM_STATE)) begin
			rd_mux = wperm;
		end else begin
			rd_mux = `PLC_RST_WORD;
		end
	end

	plc_line_input #(
		.LINES(32)
	) u_input (
		.ref_clk  (ref_clk),
		.reset    (reset),
		.pad_in   (pad_in),
		.filter_on(filt_en),
		.level    (level)
	);

	// One wait state keeps reads behind any write just before
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			phase     <= PLC_PH_IDLE;
			addr_q    <= '0;
			wr_q      <= 1'b0;
			sel_hi_q  <= 1'b0;
			hreadyout <= 1'b1;
			hrdata    <= `PLC_RST_WORD;
		end else if (data_go) begin
			phase     <= PLC_PH_IDLE;
			hreadyout <= 1'b1;
			hrdata    <= rd_go ? (rd_mux & IMPL_MASK) : `PLC_RST_WORD;
		end else if (take) begin
			phase     <= PLC_PH_DATA;
			addr_q    <= haddr[`PLC_ADDR_W-1:0];
			sel_hi_q  <= |haddr[31:`PLC_ADDR_W];
			wr_q      <= hwrite;
			hreadyout <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			hresp <= `PLC_HRESP_OKAY;
		end else begin
			hresp <= `PLC_HRESP_OKAY;
		end
	end

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			owner    <= (OWNER_RESET & IMPL_MASK) | FIXED_OWN;
			driver   <= `PLC_RST_WORD;
			filt_en  <= `PLC_RST_WORD;
			odata    <= `PLC_RST_WORD;
			irq_mask <= `PLC_RST_WORD;
			wperm    <= `PLC_RST_WORD;
			pending  <= `PLC_RST_WORD;
		end else begin
			owner    <= next_owner;
			driver   <= next_driver;
			filt_en  <= next_filt_en;
			odata    <= next_odata;
			irq_mask <= next_irq_mask;
			wperm    <= next_wperm;
			pending  <= next_pending;
		end
	end

	// Pin side and sampled levels, all registered
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			pin_q     <= `PLC_RST_WORD;
			pin_prev  <= `PLC_RST_WORD;
			primed    <= 1'b0;
			pad_out   <= `PLC_RST_WORD;
			pad_oe    <= `PLC_RST_WORD;
			periph_in <= `PLC_RST_WORD;
			irq       <= 1'b0;
		end else begin
			pin_q     <= level & IMPL_MASK;
			pin_prev  <= pin_q;
			primed    <= 1'b1;
			pad_oe    <= ((owner & driver) | (~owner & periph_oe)) & IMPL_MASK;
			pad_out   <= ((owner & odata) | (~owner & periph_out)) & IMPL_MASK;
			periph_in <= level & IMPL_MASK;
			irq       <= |(next_pending & next_irq_mask);
		end
	end

	property p_release;
		@(posedge ref_clk) disable iff (reset)
		(w_rel != '0) |=> ((owner & $past(w_rel) & MUXED_MASK) == '0);
	endproperty
	a_release: assert property (p_release) else $error("released line still owned");

	property p_owner_read;
		@(posedge ref_clk) disable iff (reset)
		(rd_go && hit(addr_q, `PLC_OFS_OWNER)) |=> (hrdata == $past(owner)) && hreadyout;
	endproperty
	a_owner_read: assert property (p_owner_read) else $error("owner read mismatch");

	property p_drv_on;
		@(posedge ref_clk) disable iff (reset)
		(w_don != '0 && w_doff == '0) |=> ((driver & $past(w_don)) == $past(w_don));
	endproperty
	a_drv_on: assert property (p_drv_on) else $error("driver not enabled");

	property p_drv_off;
		@(posedge ref_clk) disable iff (reset)
		(w_doff != '0) |=> ##1 ((pad_oe & owner & $past(w_doff, 2)) == '0);
	endproperty
	a_drv_off: assert property (p_drv_off) else $error("driver still on");

	property p_filt;
		@(posedge ref_clk) disable iff (reset)
		(w_fon != '0 || w_foff != '0) |=>
			(filt_en == (($past(filt_en) | $past(w_fon)) & ~$past(w_foff)));
	endproperty
	a_filt: assert property (p_filt) else $error("filter state wrong");

	property p_set_clr;
		@(posedge ref_clk) disable iff (reset)
		(w_high != '0 || w_low != '0) |=>
			((odata & $past(w_high) & ~$past(w_low)) == ($past(w_high) & ~$past(w_low)))
			&& ((odata & $past(w_low)) == '0);
	endproperty
	a_set_clr: assert property (p_set_clr) else $error("drive value wrong");

	property p_perm;
		@(posedge ref_clk) disable iff (reset)
		w_latch |=> ((odata & ~$past(wperm)) == ($past(odata) & ~$past(wperm)));
	endproperty
	a_perm: assert property (p_perm) else $error("unpermitted line changed");

	property p_irq;
		@(posedge ref_clk) disable iff (reset)
		((chg_set & next_irq_mask) != '0) |=> irq && ((pending & $past(chg_set)) != '0);
	endproperty
	a_irq: assert property (p_irq) else $error("change not flagged");

	property p_rd_clear;
		@(posedge ref_clk) disable iff (reset)
		(rd_pend && chg_set == '0) |=> (pending == '0) ##1 (!irq || pending != '0);
	endproperty
	a_rd_clear: assert property (p_rd_clear) else $error("pending not cleared");

	property p_unimpl;
		@(posedge ref_clk) disable iff (reset)
		hreadyout |-> ((hrdata & ~IMPL_MASK) == '0) && ((pad_oe & ~IMPL_MASK) == '0);
	endproperty
	a_unimpl: assert property (p_unimpl) else $error("unimplemented bit set");

	property p_take;
		@(posedge ref_clk) disable iff (reset)
		(w_take != '0) |=> ((owner & $past(w_take)) == $past(w_take));
	endproperty
	a_take: assert property (p_take) else $error("taken line not owned");

	property p_drv_read;
		@(posedge ref_clk) disable iff (reset)
		(rd_go && hit(addr_q, `PLC_OFS_DRV_STATE)) |=> (hrdata == $past(driver));
	endproperty
	a_drv_read: assert property (p_drv_read) else $error("driver read wrong");

	property p_filt_off;
		@(posedge ref_clk) disable iff (reset)
		(w_foff != '0) |=> ((filt_en & $past(w_foff)) == '0);
	endproperty
	a_filt_off: assert property (p_filt_off) else $error("filter still on");

	property p_filt_read;
		@(posedge ref_clk) disable iff (reset)
		(rd_go && hit(addr_q, `PLC_OFS_FILT_STATE)) |=> (hrdata == $past(filt_en));
	endproperty
	a_filt_read: assert property (p_filt_read) else $error("filter read wrong");

	property p_latch_read;
		@(posedge ref_clk) disable iff (reset)
		(rd_go && hit(addr_q, `PLC_OFS_DRV_LATCH)) |=> (hrdata == $past(odata));
	endproperty
	a_latch_read: assert property (p_latch_read) else $error("latch read wrong");

	property p_latch_wr;
		@(posedge ref_clk) disable iff (reset)
		w_latch |=> ((odata & $past(wperm)) == ($past(hwdata) & $past(wperm)));
	endproperty
	a_latch_wr: assert property (p_latch_wr) else $error("permitted write lost");

	property p_pin_read;
		@(posedge ref_clk) disable iff (reset)
		(rd_go && hit(addr_q, `PLC_OFS_PIN_LEVEL)) |=> (hrdata == $past(pin_q));
	endproperty
	a_pin_read: assert property (p_pin_read) else $error("pin level read wrong");

	property p_irq_on;
		@(posedge ref_clk) disable iff (reset)
		(w_ion != '0) |=> ((irq_mask & $past(w_ion)) == $past(w_ion));
	endproperty
	a_irq_on: assert property (p_irq_on) else $error("interrupt not enabled");

	property p_irq_level;
		@(posedge ref_clk) disable iff (reset)
		irq == ((pending & irq_mask) != '0);
	endproperty
	a_irq_level: assert property (p_irq_level) else $error("irq level wrong");

	property p_unmapped;
		@(posedge ref_clk) disable iff (reset)
		(data_go && sel_hi_q) |=> (hrdata == '0);
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

endmodule

// ### verification/plc_pin_model.sv
// Pad and peripheral stand-in for the parallel line controller
module plc_pin_model
	import plc_pkg::*;
(
	input  wire logic [31:0] pad_out,
	input  wire logic [31:0] pad_oe,
	input  wire logic [31:0] ext_lvl,
	input  wire logic [31:0] per_val,
	input  wire logic [31:0] per_en,
	output logic      [31:0] pad_in,
	output logic      [31:0] periph_out,
	output logic      [31:0] periph_oe
);
	timeunit 1ns;
	timeprecision 1ps;
	// Undriven pads follow the outside level; no pulls modelled
	assign pad_in     = (pad_oe & pad_out) | (~pad_oe & ext_lvl);
	assign periph_out = per_val;
	assign periph_oe  = per_en;
endmodule

// ### verification/plc_top_tb_top.sv
// Self-checking bench for the parallel line controller
module plc_top_tb_top
	import plc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {
		logic [7:0] wa;
		plc_word_t  wd;
		logic [7:0] ra;
		plc_word_t  exp;
	} plc_row_t;
	logic      ref_clk, reset, hsel, hwrite, hreadyout, hresp, irq;
	logic      [1:0] htrans;
	logic      [2:0] hsize;
	plc_word_t haddr, hwdata, hrdata, pad_in, pad_out, pad_oe;
	plc_word_t periph_out, periph_oe, periph_in, ext_lvl, per_val, per_en, rd;
	int        fails, cmp_count;
	logic      [7:0] rst_regs [6] = '{8'h08, 8'h18, 8'h28, 8'h38, 8'h48, 8'h4C};
	plc_row_t  rows [16] = '{
		'{8'h10, 32'h000000FF, 8'h18, 32'h000000FF},
		'{8'h10, 32'h00000000, 8'h18, 32'h000000FF},
		'{8'h14, 32'h0000000F, 8'h18, 32'h000000F0},
		'{8'h20, 32'h00FF0000, 8'h28, 32'h00FF0000},
		'{8'h24, 32'h000F0000, 8'h28, 32'h00F00000},
		'{8'h30, 32'h000000A5, 8'h38, 32'h000000A5},
		'{8'h34, 32'h00000081, 8'h38, 32'h00000024},
		'{8'h30, 32'h80000000, 8'h38, 32'h00000024},
		'{8'h00, 32'hFFFFFFFF, 8'h08, 32'h7FFFFFFF},
		'{8'h04, 32'hF0000000, 8'h08, 32'h0FFFFFFF},
		'{8'h38, 32'hFFFFFFFF, 8'h38, 32'h00000024},
		'{8'hA0, 32'h0000FF00, 8'hA8, 32'h0000FF00},
		'{8'h38, 32'hFFFFFFFF, 8'h38, 32'h0000FF24},
		'{8'h0C, 32'hFFFFFFFF, 8'h0C, 32'h00000000},
		'{8'h40, 32'h00000100, 8'h48, 32'h00000100},
		'{8'hA4, 32'h0000F000, 8'hA8, 32'h00000F00}
	};

	// Line 31 left unimplemented to exercise the ignore path
	plc_top #(.IMPL_MASK(32'h7FFFFFFF)) dut (
		.ref_clk(ref_clk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .pad_in(pad_in),
		.pad_out(pad_out), .pad_oe(pad_oe), .periph_out(periph_out),
		.periph_oe(periph_oe), .periph_in(periph_in), .irq(irq));
	plc_pin_model pins (
		.pad_out(pad_out), .pad_oe(pad_oe), .ext_lvl(ext_lvl), .per_val(per_val),
		.per_en(per_en), .pad_in(pad_in), .periph_out(periph_out), .periph_oe(periph_oe));

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	task automatic chk(input string what, input plc_word_t exp, input plc_word_t got);
		cmp_count++;
		if (got !== exp) begin
			fails++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask

	// Bounded wait for hready sampled high at a rising edge
	task automatic wait_ready();
		int n;
		n = 0;
		@(posedge ref_clk);
		while (hreadyout !== 1'b1) begin
			n++;
			if (n > 50) begin
				fails++;
				give_verdict();
			end
			@(posedge ref_clk);
		end
	endtask

	task automatic bus(input logic wr, input plc_word_t a, input plc_word_t d);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'b10;
		hwrite <= wr;
		wait_ready();
		htrans <= 2'b00;
		hwdata <= d;
		wait_ready();
		rd = hrdata;
		chk("hresp", 32'h0, {31'h0, hresp});
	endtask

	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end

	initial begin
		fails = 0;
		cmp_count = 0;
		reset = 1'b1;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'b010;
		hwdata = 32'h0;
		ext_lvl = 32'h0;
		per_val = 32'h0;
		per_en = 32'h0;
		repeat (4) @(posedge ref_clk);
		reset <= 1'b0;
		chk("pad_oe", 32'h0, pad_oe);
		foreach (rst_regs[i]) begin
			bus(1'b0, {24'h0, rst_regs[i]}, 32'h0);
			chk("reset value", 32'h0, rd);
		end
		foreach (rows[i]) begin
			bus(1'b1, {24'h0, rows[i].wa}, rows[i].wd);
			bus(1'b0, {24'h0, rows[i].ra}, 32'h0);
			chk("register view", rows[i].exp, rd);
		end
		bus(1'b0, 32'h00000100, 32'h0);
		chk("unmapped read", 32'h0, rd);
		per_val <= 32'hA0000000;
		per_en <= 32'hF0000000;
		ext_lvl <= 32'h00000100;
		repeat (10) @(posedge ref_clk);
		chk("pad_oe", 32'h700000F0, pad_oe & 32'h7FFFFFFF);
		chk("pad_out", 32'h20000020, pad_out & 32'h700000F0);
		chk("irq", 32'h1, {31'h0, irq});
		bus(1'b0, 32'h3C, 32'h0);
		chk("pin level", 32'h20000120, rd);
		chk("periph_in", 32'h20000120, periph_in);
		bus(1'b0, 32'h4C, 32'h0);
		chk("pending", 32'h00000100, rd);
		bus(1'b0, 32'h4C, 32'h0);
		chk("pending after read", 32'h0, rd);
		chk("irq", 32'h0, {31'h0, irq});
		// A change on a line without interrupt enable stays silent
		ext_lvl <= 32'h00000300;
		repeat (10) @(posedge ref_clk);
		bus(1'b0, 32'h4C, 32'h0);
		chk("masked pending", 32'h0, rd);
		bus(1'b1, 32'h40, 32'h00101000);
		bus(1'b0, 32'h4C, 32'h0);
		// Short pulse: passes line 12 unfiltered, dropped on filtered line 20
		ext_lvl <= 32'h00101300;
		repeat (2) @(posedge ref_clk);
		ext_lvl <= 32'h00000300;
		repeat (10) @(posedge ref_clk);
		// Irq looked at before the read, which clears it
		chk("irq", 32'h1, {31'h0, irq});
		bus(1'b0, 32'h4C, 32'h0);
		chk("filtered pending", 32'h00001000, rd);
		chk("irq after read", 32'h0, {31'h0, irq});
		// Write-one clear of a fresh change on line 8
		ext_lvl <= 32'h00000200;
		repeat (10) @(posedge ref_clk);
		chk("irq", 32'h1, {31'h0, irq});
		bus(1'b1, 32'h4C, 32'h00000100);
		chk("irq after clear", 32'h0, {31'h0, irq});
		bus(1'b1, 32'h44, 32'h00100000);
		bus(1'b0, 32'h48, 32'h0);
		chk("irq mask", 32'h00001100, rd);
		// Mid-run reset returns the views to their reset values
		reset <= 1'b1;
		repeat (2) @(posedge ref_clk);
		chk("pad_oe in reset", 32'h0, pad_oe);
		chk("irq in reset", 32'h0, {31'h0, irq});
		reset <= 1'b0;
		bus(1'b0, 32'h08, 32'h0);
		chk("owner after reset", 32'h0, rd);
		bus(1'b0, 32'h18, 32'h0);
		chk("driver after reset", 32'h0, rd);
		give_verdict();
	end
endmodule
